/* cbuf_pkg.sv */
// Package for the capture buffer control block: sizes, pin slots,
// register offsets, field positions and reset values.
// Assumes a 32-bit plain register port with byte addresses.
package cbuf_pkg;
	// ----------------------------------------
	// Buffer geometry
	// ----------------------------------------
	localparam int DEPTH = 4096;
	localparam int DW    = 8;
	localparam int RW    = 32;
	localparam int RAW   = 4;

	// ----------------------------------------
	// Slots of the pin synchroniser vector
	// ----------------------------------------
	localparam int NPIN     = 4;
	localparam int PIN_WEN  = 0;
	localparam int PIN_REN  = 1;
	localparam int PIN_RCLK = 2;
	localparam int PIN_RST  = 3;

	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [RAW-1:0] REG_CTRL  = 4'h0;
	localparam logic [RAW-1:0] REG_STAT  = 4'h4;
	localparam logic [RAW-1:0] REG_MASK  = 4'h8;
	localparam logic [RAW-1:0] REG_STATE = 4'hc;

	// ----------------------------------------
	// Fields and reset values
	// ----------------------------------------
	localparam int CTRL_HALT  = 0;
	localparam int CTRL_SPLIT = 1;
	localparam int NCTRL      = 2;
	localparam logic [NCTRL-1:0] CTRL_RST = 2'h0;
	localparam int EV_FULL = 0;
	localparam int EV_OOR  = 1;
	localparam int EV_OVF  = 2;
	localparam int NEV     = 3;
	localparam logic [NEV-1:0] EV_RST = 3'h0;
	localparam int ST_FULL  = 0;
	localparam int ST_EMPTY = 1;
	localparam int ST_OOR   = 2;
	localparam int ST_WSYNC = 3;
	localparam int ST_CNT   = 16;
endpackage

/* capture_buffer_control.sv */
// Capture buffer control: 4K-byte store filled from the converter on ref_clk,
// drained by an external reader whose read clock is sampled on ref_clk.
// Assumes read clock, strobes and buffer reset arrive asynchronously on pins.
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
module capture_buffer_control #(
	parameter int DEPTH = cbuf_pkg::DEPTH  // Buffer size in bytes
) (
	input  wire logic                  ref_clk,                // Sample clock
	input  wire logic                  rst,                    // Async reset, high
	input  wire logic [cbuf_pkg::DW-1:0] conv_data,            // Converted byte
	input  wire logic                  conv_over_range,        // Input outside range
	input  wire logic                  wr_strobe_pin,          // Write strobe, async
	input  wire logic                  rd_strobe_pin,          // Read strobe, async
	input  wire logic                  rd_clk_pin,             // Reader clock, async
	input  wire logic                  buf_reset_pin,          // Buffer reset, high
	output logic [cbuf_pkg::DW-1:0]    data_port1,             // Later or only byte
	output logic [cbuf_pkg::DW-1:0]    data_port2_o,           // Earlier byte
	output logic                       data_port2_oe,          // Port two driven
	output logic                       data_ready,             // New data pulse
	output logic                       write_strobe_sync_echo, // Synced strobe
	output logic                       buffer_full_flag,       // Buffer full
	output logic                       buffer_empty_flag,      // Buffer empty
	output logic                       out_of_range_flag,      // Sticky overrange
	input  wire logic [cbuf_pkg::RAW-1:0] reg_addr,            // Register address
	input  wire logic [cbuf_pkg::RW-1:0]  reg_wdata,           // Write data
	input  wire logic                  reg_wr,                 // Write strobe
	input  wire logic                  reg_rd,                 // Read strobe
	output logic [cbuf_pkg::RW-1:0]    reg_rdata,              // Read data
	output logic                       irq                     // Interrupt level
);
	import cbuf_pkg::*;

	localparam int AW = $clog2(DEPTH);
	localparam int PW = AW + 1;
	localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);
	localparam logic [PW-1:0] ONE_P   = PW'(1);
	localparam logic [PW-1:0] TWO_P   = PW'(2);

	// Occupancy tests shared by flags, events and the overrange clear
	function automatic logic cnt_full(input logic [PW-1:0] c);
		return c == DEPTH_P;
	endfunction

	function automatic logic cnt_empty(input logic [PW-1:0] c);
		return c == '0;
	endfunction

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [NPIN-1:0] s1, s2, s3, filt;
	logic            rclk_q;
	logic            wen, ren, brst, rd_edge;

	// Three stages; a level counts once stages two and three agree
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s1   <= '0;
			s2   <= '0;
			s3   <= '0;
			filt <= '0;
		end else begin
			s1   <= {buf_reset_pin, rd_clk_pin, rd_strobe_pin, wr_strobe_pin};
			s2   <= s1;
			s3   <= s2;
			filt <= (s2 & ~(s2 ^ s3)) | (filt & (s2 ^ s3));
		end
	end

	// Read clock edge finder on the filtered level
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			rclk_q <= 1'b0;
		else
			rclk_q <= filt[PIN_RCLK];
	end

	assign wen     = filt[PIN_WEN];
	assign ren     = filt[PIN_REN];
	assign brst    = filt[PIN_RST];
	assign rd_edge = filt[PIN_RCLK] & ~rclk_q;
	assign write_strobe_sync_echo = wen;

	// ----------------------------------------
	// Pointers and occupancy
	// ----------------------------------------
	logic [DW-1:0]  mem [DEPTH];
	logic [PW-1:0]  wp, rp, count, rd_amt, count_next;
	logic [NCTRL-1:0] ctrl;
	logic           full_now, empty_now, do_write, overwrite, do_read, pair;

	// Both pointers live on ref_clk, so no pointer crossing is needed
	assign count     = wp - rp;
	assign full_now  = cnt_full(count);
	assign empty_now = cnt_empty(count);
	assign do_write  = wen & ~brst & (~full_now | ~ctrl[CTRL_HALT]);
	assign overwrite = do_write & full_now;
	assign do_read   = rd_edge & ren & ~brst & ~empty_now;
	assign pair      = ctrl[CTRL_SPLIT] & (count > ONE_P);
	assign rd_amt    = do_read ? (pair ? TWO_P : ONE_P) : '0;
	assign count_next = count + PW'(do_write) - PW'(overwrite) - rd_amt;

	// Write pointer advances once per stored byte
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			wp <= '0;
		else if (brst)
			wp <= '0;
		else if (do_write)
			wp <= wp + ONE_P;
	end

	// Read pointer; an overwrite pushes it past the lost oldest byte
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			rp <= '0;
		else if (brst)
			rp <= '0;
		else
			rp <= rp + PW'(overwrite) + rd_amt;
	end

	// Storage array, no reset so it maps onto block memory
	always_ff @(posedge ref_clk) begin
		if (do_write)
			mem[wp[AW-1:0]] <= conv_data;
	end

	// ----------------------------------------
	// Output ports
	// ----------------------------------------
	// Port one holds the last byte between reads
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			data_port1   <= '0;
			data_port2_o <= '0;
		end else if (do_read) begin
			data_port1 <= pair ? mem[AW'(rp + ONE_P)] : mem[rp[AW-1:0]];
			if (pair)
				data_port2_o <= mem[rp[AW-1:0]];
		end
	end

	// One-cycle marker that fresh data stand on the ports
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			data_ready <= 1'b0;
		else
			data_ready <= do_read;
	end

	assign data_port2_oe = ctrl[CTRL_SPLIT];

	// ----------------------------------------
	// Flags
	// ----------------------------------------
	// Full tracks the sample clock, empty only moves on read clock edges or a buffer reset
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			buffer_full_flag  <= 1'b0;
			buffer_empty_flag <= 1'b1;
		end else if (brst) begin
			buffer_full_flag  <= 1'b0;
			buffer_empty_flag <= 1'b1;
		end else begin
			buffer_full_flag <= cnt_full(count_next);
			if (rd_edge)
				buffer_empty_flag <= cnt_empty(count_next);
		end
	end

	// Sticky overrange; a new overrange wins over the read-out clear
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			out_of_range_flag <= 1'b0;
		else if (brst)
			out_of_range_flag <= 1'b0;
		else if (do_write & conv_over_range)
			out_of_range_flag <= 1'b1;
		else if (do_read & cnt_empty(count_next))
			out_of_range_flag <= 1'b0;
	end

	// ----------------------------------------
	// Register port and interrupt
	// ----------------------------------------
	logic [NEV-1:0] stat, mask, ev;

	assign ev[EV_FULL] = ~buffer_full_flag & cnt_full(count_next) & ~brst;
	assign ev[EV_OOR]  = do_write & conv_over_range;
	assign ev[EV_OVF]  = overwrite;

	// Control and mask writes
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl <= CTRL_RST;
			mask <= EV_RST;
		end else if (reg_wr) begin
			if (reg_addr == REG_CTRL)
				ctrl <= reg_wdata[NCTRL-1:0];
			if (reg_addr == REG_MASK)
				mask <= reg_wdata[NEV-1:0];
		end
	end

	// Status is write-one-to-clear; an event in the same cycle wins
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			stat <= EV_RST;
		else if (reg_wr && reg_addr == REG_STAT)
			stat <= (stat & ~reg_wdata[NEV-1:0]) | ev;
		else
			stat <= stat | ev;
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			reg_rdata <= '0;
		else if (reg_rd) begin
			case (reg_addr)
				REG_CTRL:  reg_rdata <= RW'(ctrl);
				REG_STAT:  reg_rdata <= RW'(stat);
				REG_MASK:  reg_rdata <= RW'(mask);
				REG_STATE: begin
					reg_rdata <= '0;
					reg_rdata[ST_FULL]  <= buffer_full_flag;
					reg_rdata[ST_EMPTY] <= buffer_empty_flag;
					reg_rdata[ST_OOR]   <= out_of_range_flag;
					reg_rdata[ST_WSYNC] <= wen;
					reg_rdata[ST_CNT +: PW] <= count;
				end
				default:   reg_rdata <= '0;
			endcase
		end else
			reg_rdata <= '0;
	end

	assign irq = |(stat & mask);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence full_and_writing;
		full_now && wen && !ctrl[CTRL_HALT] && !brst && !do_read;
	endsequence

	sequence full_and_halted;
		full_now && ctrl[CTRL_HALT] && !brst;
	endsequence

	sequence single_read;
		do_read && !pair;
	endsequence

	sync_agree_a: assert property ((s2[PIN_WEN] == s3[PIN_WEN]) |=>
		filt[PIN_WEN] == $past(s2[PIN_WEN])) else $error("strobe sync wrong");
	write_step_a: assert property (wen && !full_now && !brst |=>
		wp == $past(wp) + ONE_P) else $error("write pointer did not step");
	read_step_a: assert property (rd_edge && ren && !empty_now && !brst && !ctrl[CTRL_SPLIT]
		&& !wen |=> rp == $past(rp) + ONE_P) else $error("read pointer did not step");
	wrap_over_a: assert property (full_and_writing |=>
		rp == $past(rp) + ONE_P && wp == $past(wp) + ONE_P) else $error("no overwrite");
	halt_hold_a: assert property (full_and_halted ##0 !do_read |=>
		wp == $past(wp)) else $error("write into halted full buffer");
	full_rise_a: assert property ($rose(buffer_full_flag) |->
		count == DEPTH_P) else $error("full flag without full buffer");
	empty_edge_a: assert property (!rd_edge && !brst |=>
		$stable(buffer_empty_flag)) else $error("empty moved off read edge");
	port_hold_a: assert property (!do_read |=>
		$stable(data_port1)) else $error("port one changed without read");
	reset_clear_a: assert property (brst |=> wp == '0 && rp == '0
		&& !buffer_full_flag && buffer_empty_flag && !out_of_range_flag)
		else $error("buffer reset incomplete");
	oor_set_a: assert property (do_write && conv_over_range && !brst |=>
		out_of_range_flag) else $error("overrange not caught");

	// Flag release, byte presentation and port two between pairs
	full_drop_a: assert property (do_read && buffer_full_flag && !brst |=>
		!buffer_full_flag) else $error("full flag held after read");
	oor_clear_a: assert property (do_read && cnt_empty(count_next) && !conv_over_range
		&& !brst |=> !out_of_range_flag) else $error("overrange kept after read-out");
	empty_drop_a: assert property (rd_edge && !brst && !empty_now && !do_read |=>
		!buffer_empty_flag) else $error("empty flag set with data held");
	pair_hold_a: assert property (!(do_read && pair) |=>
		$stable(data_port2_o)) else $error("port two changed outside a pair");
	read_out_a: assert property (single_read |=> data_ready
		&& data_port1 == $past(mem[rp[AW-1:0]])) else $error("read byte not presented");
endmodule // capture_buffer_control

/* reader_model.sv */
// Reader on the far side of the capture buffer: makes the read clock
// and the read strobe. Assumes want is driven by the bench's own clock.
`timescale 1ns/1ps
module reader_model (
	input  wire logic want,      // Bench asks for reads
	input  wire logic wr_active, // Write strobe pin level
	output logic      rd_clk,    // Free-running read clock
	output logic      rd_strobe  // Read strobe
);
	// ----
	// Read clock, 125 ns, phase unrelated to ref_clk
	// ----
	initial begin
		rd_clk = 1'b0;
		#3.3;
		forever #62.5 rd_clk = ~rd_clk;
	end

	// Strobe moves on the falling edge, clear of the rising read edge;
	// it is never raised while a capture is running
	initial rd_strobe = 1'b0;
	always @(negedge rd_clk) begin
		if (!want)
			rd_strobe <= 1'b0;
		else if (!wr_active)
			rd_strobe <= 1'b1;
	end
endmodule // reader_model

/* testbench.sv */
// Self-checking bench for the capture buffer control block.
// Assumes the reader model makes the read clock and read strobe.
`timescale 1ns/1ps
module testbench;
	import cbuf_pkg::*;
	logic        ref_clk, rst, ovr, wr_pin, rd_go, brst, reg_wr, reg_rd;
	logic        rd_clk, rd_stb, drdy, echo, full, empty, oor, oe, irq;
	logic [7:0]  conv_data, p1, p2, held;
	logic [3:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [7:0]  q1[$], q2[$];
	int          err_count, comparisons;

	capture_buffer_control #(.DEPTH(16)) dut (.ref_clk(ref_clk), .rst(rst),
		.conv_data(conv_data), .conv_over_range(ovr), .wr_strobe_pin(wr_pin),
		.rd_strobe_pin(rd_stb), .rd_clk_pin(rd_clk), .buf_reset_pin(brst),
		.data_port1(p1), .data_port2_o(p2), .data_port2_oe(oe), .data_ready(drdy),
		.write_strobe_sync_echo(echo), .buffer_full_flag(full),
		.buffer_empty_flag(empty), .out_of_range_flag(oor), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq(irq));
	reader_model reader (.want(rd_go), .wr_active(wr_pin), .rd_clk(rd_clk),
		.rd_strobe(rd_stb));

	// ----
	// Clock, counting sample stream, read capture
	// ----
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) conv_data <= rst ? 8'h00 : conv_data + 8'h01;
	// Registered outputs read right after the edge show pre-edge values
	always @(posedge ref_clk) if (drdy === 1'b1) begin
		q1.push_back(p1);
		q2.push_back(p2);
	end

	// ----
	// Bus tasks and checks
	// ----
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s: expected %h, seen %h", nm, exp, got);
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge ref_clk) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v; end
		@(posedge ref_clk) reg_wr <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge ref_clk) begin reg_rd <= 1'b1; reg_addr <= a; end
		@(posedge ref_clk) reg_rd <= 1'b0;
		@(posedge ref_clk) chk("reg", exp, reg_rdata);
	endtask
	// One capture: ctl goes to the control word, strobe high until n edges after the overrange pulse
	task capture(input logic [1:0] ctl, input int n);
		int k;
		wr(REG_CTRL, {30'h0, ctl});
		@(posedge ref_clk) wr_pin <= 1'b1;
		k = 0;
		while (echo !== 1'b1 && k < 20) begin @(posedge ref_clk); k++; end
		chk("echo", 1, echo);
		@(posedge ref_clk) ovr <= 1'b1;
		@(posedge ref_clk) ovr <= 1'b0;
		repeat (n) @(posedge ref_clk);
		wr_pin <= 1'b0;
		repeat (40) @(posedge ref_clk); // Covers one read clock for empty
		chk("oe", {31'h0, ctl[1]}, oe);
		$display("test capture %h done", ctl);
	endtask
	// Read until empty; bytes must run on without gap, older on port two
	task drain(input logic sp);
		int k;
		q1.delete();
		q2.delete();
		@(posedge ref_clk) rd_go <= 1'b1;
		k = 0;
		while (empty !== 1'b1 && k < 3000) begin @(posedge ref_clk); k++; end
		rd_go <= 1'b0;
		repeat (70) @(posedge ref_clk);
		chk("count", sp ? 8 : 16, q1.size());
		for (k = 1; k < q1.size(); k++)
			chk("seq", 8'(q1[k-1] + (sp ? 8'h02 : 8'h01)), q1[k]);
		for (k = 0; sp && k < q1.size(); k++)
			chk("pair", 8'(q2[k] + 8'h01), q1[k]);
		chk("full", 0, full);
		chk("empty", 1, empty);
		chk("oor", 0, oor);
		held = p1;
		repeat (100) @(posedge ref_clk);
		chk("hold", held, p1);
		$display("test drain %b done", sp);
	endtask

	task report_and_stop;
		$display("comparisons %0d, mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		#100000;
		err_count++;
		report_and_stop();
	end

	// ----
	// Main sequence
	// ----
	initial begin
		{rst, ovr, wr_pin, rd_go, brst, reg_wr, reg_rd} = 7'h40;
		{reg_addr, reg_wdata} = 36'h0;
		err_count = 0;
		comparisons = 0;
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (5) @(posedge ref_clk);
		rd(REG_CTRL, 32'h0);
		rd(REG_MASK, 32'h0);
		rd(REG_STATE, 32'h2);
		rd(4'h2, 32'h0);
		wr(REG_MASK, 32'h1);
		capture(2'b01, 30); // Auto halt: later bytes dropped
		chk("full", 1, full);
		chk("oor", 1, oor);
		chk("empty", 0, empty);
		rd(REG_STATE, 32'h0010_0005);
		rd(REG_STAT, 32'h3);
		chk("irq", 1, irq);
		drain(1'b0);
		wr(REG_STAT, 32'h7);
		rd(REG_STAT, 32'h0);
		chk("irq", 0, irq);
		capture(2'b10, 30); // No halt: wrap and overwrite
		rd(REG_STAT, 32'h7);
		drain(1'b1);
		capture(2'b01, 3);
		@(posedge ref_clk) brst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		brst <= 1'b0;
		repeat (10) @(posedge ref_clk);
		chk("empty", 1, empty);
		chk("oor", 0, oor);
		rd(REG_STATE, 32'h2);
		$display("test buffer reset done");
		report_and_stop();
	end
endmodule // testbench
